// ---- src/cmi_i2c_slave_regs.sv ----
// I2C slave port with control and balance register bank of the cell monitor
`timescale 1ns/10ps
`default_nettype none
module cmi_i2c_slave_regs import cmi_pkg::*; #(
  parameter longint BUS_TIMEOUT_PERIOD_SHORT_CYC = CMI_BUS_TIMEOUT_PERIOD_SHORT_CYC,
  parameter longint BUS_TIMEOUT_PERIOD_LONG_CYC = CMI_BUS_TIMEOUT_PERIOD_LONG_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic trim_long_timeout,
  input wire logic wake_above_threshold,
  input wire logic wake_below_release,
  output logic bus_busy,
  output logic sleep_request,
  output logic external_wake_flag,
  output logic monitor_enable,
  output logic [2:0] cell_tap_select,
  output logic [7:0] monitor_switch_sel,
  output logic [7:0] balance_switch_enables
);

  logic [CMI_SYNC_W-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wake_hi_s;
  logic wake_lo_s;
  logic trim_s;
  logic wake_detect;

  cmi_sync3 u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({trim_long_timeout, wake_below_release, wake_above_threshold, sda_in, scl_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign wake_hi_s = pins_s[2];
  assign wake_lo_s = pins_s[3];
  assign trim_s = pins_s[4];

  cmi_wake_filter u_wake (
    .clock(clock),
    .sys_rst(sys_rst),
    .wake_above(wake_hi_s),
    .wake_detect(wake_detect)
  );

  // Unmapped pointers read as zero
  function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input logic [7:0] ctrl,
                                         input logic [7:0] bal);
    if (ptr == CMI_CTRL_OFS) begin
      rd_byte = ctrl;
    end else if (ptr == CMI_BAL_OFS) begin
      rd_byte = bal;
    end else begin
      rd_byte = CMI_UNMAPPED_RD;
    end
  endfunction : rd_byte

  // Bus state
  cmi_state_e state_ff, nxt_state;
  logic scl_d_ff, nxt_scl_d;
  logic sda_d_ff, nxt_sda_d;
  logic busy_ff, nxt_busy;
  logic [7:0] shift_ff, nxt_shift;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic got8_ff, nxt_got8;
  logic [1:0] idx_ff, nxt_idx;
  logic rw_ff, nxt_rw;
  logic nack_ff, nxt_nack;
  logic [7:0] ptr_ff, nxt_ptr;
  logic sda_oe_ff, nxt_sda_oe;
  logic [CMI_BUS_TIMEOUT_PERIOD_W-1:0] bus_timeout_period_ff, nxt_bus_timeout_period;
  // Register bank
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] bal_ff, nxt_bal;
  logic [7:0] mon_sw_ff, nxt_mon_sw;

  cmi_bus_ev_s ev;
  logic [CMI_BUS_TIMEOUT_PERIOD_W-1:0] bus_timeout_period_lim;
  logic timeout;
  logic wr_en;
  logic [7:0] rd_val;

  assign bus_timeout_period_lim = trim_s ? CMI_BUS_TIMEOUT_PERIOD_W'(BUS_TIMEOUT_PERIOD_LONG_CYC) : CMI_BUS_TIMEOUT_PERIOD_W'(BUS_TIMEOUT_PERIOD_SHORT_CYC);

  always_comb begin
    ev.start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    ev.stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    ev.rise = scl_s & ~scl_d_ff;
    ev.fall = ~scl_s & scl_d_ff;
  end

  // Bus protocol engine
  always_comb begin
    nxt_state = state_ff;
    nxt_scl_d = scl_s;
    nxt_sda_d = sda_s;
    nxt_busy = busy_ff;
    nxt_shift = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_got8 = got8_ff;
    nxt_idx = idx_ff;
    nxt_rw = rw_ff;
    nxt_nack = nack_ff;
    nxt_ptr = ptr_ff;
    nxt_sda_oe = sda_oe_ff;
    wr_en = 1'b0;
    rd_val = rd_byte(ptr_ff, ctrl_ff, bal_ff);
    timeout = busy_ff && (bus_timeout_period_ff >= bus_timeout_period_lim);
    // Timer only runs inside a frame; every SCL fall or start rearms it
    if (!busy_ff || ev.start || ev.fall) begin
      nxt_bus_timeout_period = '0;
    end else begin
      nxt_bus_timeout_period = bus_timeout_period_ff + 22'h000001;
    end
    if (timeout) begin
      nxt_state = CMI_ST_IDLE;
      nxt_busy = 1'b0;
      nxt_sda_oe = 1'b0;
    end else if (ev.start) begin
      nxt_state = CMI_ST_RX;
      nxt_busy = 1'b1;
      nxt_bit_cnt = 3'h0;
      nxt_got8 = 1'b0;
      nxt_idx = 2'h0;
      nxt_sda_oe = 1'b0;
    end else if (ev.stop) begin
      nxt_state = CMI_ST_IDLE;
      nxt_busy = 1'b0;
      nxt_sda_oe = 1'b0;
    end else begin
      unique case (state_ff)
        CMI_ST_IDLE: begin
          nxt_sda_oe = 1'b0;
        end
        CMI_ST_RX: begin
          if (ev.rise) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              nxt_got8 = 1'b1;
            end
          end else if (ev.fall && got8_ff) begin
            nxt_got8 = 1'b0;
            nxt_state = CMI_ST_RX_ACK;
            nxt_sda_oe = 1'b1;
            nxt_idx = (idx_ff == 2'h2) ? 2'h2 : idx_ff + 2'h1;
            if (idx_ff == 2'h0) begin
              nxt_rw = shift_ff[0];
              if (shift_ff[7:1] != CMI_SLAVE_ADDR) begin
                nxt_state = CMI_ST_IDLE;
                nxt_sda_oe = 1'b0;
              end
            end else if (idx_ff == 2'h1) begin
              nxt_ptr = shift_ff;
            end else begin
              wr_en = 1'b1;
            end
          end
        end
        CMI_ST_RX_ACK: begin
          if (ev.fall) begin
            nxt_bit_cnt = 3'h0;
            if (idx_ff == 2'h1 && rw_ff) begin
              nxt_state = CMI_ST_TX;
              nxt_shift = rd_val;
              nxt_sda_oe = ~rd_val[7];
            end else begin
              nxt_state = CMI_ST_RX;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        CMI_ST_TX: begin
          if (ev.fall) begin
            if (bit_cnt_ff == 3'h7) begin
              nxt_state = CMI_ST_TX_ACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
              nxt_bit_cnt = bit_cnt_ff + 3'h1;
            end
          end
        end
        CMI_ST_TX_ACK: begin
          if (ev.rise) begin
            nxt_nack = sda_s;
          end else if (ev.fall) begin
            nxt_bit_cnt = 3'h0;
            if (nack_ff) begin
              nxt_state = CMI_ST_IDLE;
            end else begin
              nxt_state = CMI_ST_TX;
              nxt_shift = rd_val;
              nxt_sda_oe = ~rd_val[7];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= CMI_ST_IDLE;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      busy_ff <= 1'b0;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      got8_ff <= 1'b0;
      idx_ff <= 2'h0;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      ptr_ff <= CMI_CTRL_OFS;
      sda_oe_ff <= 1'b0;
      bus_timeout_period_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      scl_d_ff <= nxt_scl_d;
      sda_d_ff <= nxt_sda_d;
      busy_ff <= nxt_busy;
      shift_ff <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      got8_ff <= nxt_got8;
      idx_ff <= nxt_idx;
      rw_ff <= nxt_rw;
      nack_ff <= nxt_nack;
      ptr_ff <= nxt_ptr;
      sda_oe_ff <= nxt_sda_oe;
      bus_timeout_period_ff <= nxt_bus_timeout_period;
    end
  end

  // Register bank; a pin wake event outranks any host write to the flag
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_bal = bal_ff;
    if (wake_lo_s) begin
      nxt_ctrl[CMI_WAKE_BIT] = 1'b0;
    end
    if (wr_en && ptr_ff == CMI_CTRL_OFS) begin
      nxt_ctrl = shift_ff;
      nxt_ctrl[CMI_SLEEP_BIT] = shift_ff[CMI_SLEEP_BIT];
    end
    if (wr_en && ptr_ff == CMI_BAL_OFS) begin
      nxt_bal = shift_ff;
    end
    if (wake_detect) begin
      nxt_ctrl[CMI_WAKE_BIT] = 1'b1;
    end
    // Flag held or being set: sleep cannot stick
    if (nxt_ctrl[CMI_WAKE_BIT] || ctrl_ff[CMI_WAKE_BIT]) begin
      nxt_ctrl[CMI_SLEEP_BIT] = 1'b0;
    end
    if (nxt_ctrl[CMI_SLEEP_BIT] && !ctrl_ff[CMI_SLEEP_BIT]) begin
      nxt_bal = 8'h00;
    end
    if (nxt_ctrl[CMI_MON_EN_BIT]) begin
      nxt_mon_sw = 8'h01 << nxt_ctrl[CMI_TAP_MSB:CMI_TAP_LSB];
    end else begin
      nxt_mon_sw = 8'h00;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= CMI_CTRL_RST;
      bal_ff <= CMI_BAL_RST;
      mon_sw_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      bal_ff <= nxt_bal;
      mon_sw_ff <= nxt_mon_sw;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign bus_busy = busy_ff;
  assign sleep_request = ctrl_ff[CMI_SLEEP_BIT];
  assign external_wake_flag = ctrl_ff[CMI_WAKE_BIT];
  assign monitor_enable = ctrl_ff[CMI_MON_EN_BIT];
  assign cell_tap_select = ctrl_ff[CMI_TAP_MSB:CMI_TAP_LSB];
  assign monitor_switch_sel = mon_sw_ff;
  assign balance_switch_enables = bal_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_start_busy;
    ev.start && !timeout |=> busy_ff && state_ff == CMI_ST_RX;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");
  property p_stop_free;
    ev.stop && !ev.start && !timeout |=> !busy_ff && !sda_oe_ff;
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("stop not taken");
  property p_rstart;
    busy_ff && ev.start && !timeout |=> busy_ff && bit_cnt_ff == 3'h0 && idx_ff == 2'h0;
  endproperty
  a_rstart: assert property (p_rstart) else $error("restart mishandled");
  property p_sda_low_phase;
    $changed(sda_oe_ff) && !ev.start && !ev.stop && !$past(timeout) |-> !scl_s;
  endproperty
  a_sda_low_phase: assert property (p_sda_low_phase) else $error("SDA moved, SCL high");
  property p_ack_hold;
    state_ff == CMI_ST_RX_ACK && ev.rise ##1 !ev.fall [*2] |-> sda_oe_ff;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack released early");
  property p_timeout;
    timeout |=> state_ff == CMI_ST_IDLE && !busy_ff ##1 !sda_oe_ff;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out not released");
  property p_bad_addr;
    state_ff == CMI_ST_RX && ev.fall && got8_ff && idx_ff == 2'h0 && !ev.start && !ev.stop
      && !timeout && shift_ff[7:1] != CMI_SLAVE_ADDR |=> !sda_oe_ff;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("foreign address acked");
  property p_wake_sleep;
    external_wake_flag |-> !sleep_request;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("sleep set with wake");
  property p_sleep_bal;
    $rose(sleep_request) |-> balance_switch_enables == 8'h00;
  endproperty
  a_sleep_bal: assert property (p_sleep_bal) else $error("balance kept on sleep");
  property p_wake_set;
    wake_detect |=> external_wake_flag && !sleep_request;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake not flagged");

  c_write: cover property (wr_en);
  c_read: cover property (state_ff == CMI_ST_TX_ACK && ev.fall && !nack_ff);
  c_timeout: cover property (timeout);

endmodule : cmi_i2c_slave_regs
`default_nettype wire

// ---- src/cmi_pkg.sv ----
// Shared constants, types and timing figures of the cell monitor I2C slave
package cmi_pkg;

  // Bus identity and register map
  localparam logic [6:0] CMI_SLAVE_ADDR = 7'h5c;
  localparam logic [7:0] CMI_CTRL_OFS = 8'h00;
  localparam logic [7:0] CMI_BAL_OFS = 8'h01;
  localparam logic [7:0] CMI_CTRL_RST = 8'h00;
  localparam logic [7:0] CMI_BAL_RST = 8'h00;
  localparam logic [7:0] CMI_UNMAPPED_RD = 8'h00;

  // Control byte field positions
  localparam int CMI_SLEEP_BIT = 7;
  localparam int CMI_WAKE_BIT = 6;
  localparam int CMI_MON_EN_BIT = 5;
  localparam int CMI_TAP_MSB = 2;
  localparam int CMI_TAP_LSB = 0;

  // Clock rate and derived counts
  localparam longint CMI_CLK_HZ = 50_000_000;
  localparam longint CMI_BUS_TIMEOUT_PERIOD_SHORT_MS = 32;
  localparam longint CMI_BUS_TIMEOUT_PERIOD_LONG_MS = 64;
  localparam longint CMI_BUS_TIMEOUT_PERIOD_SHORT_CYC = CMI_BUS_TIMEOUT_PERIOD_SHORT_MS * CMI_CLK_HZ / 1000;
  localparam longint CMI_BUS_TIMEOUT_PERIOD_LONG_CYC = CMI_BUS_TIMEOUT_PERIOD_LONG_MS * CMI_CLK_HZ / 1000;
  localparam int CMI_BUS_TIMEOUT_PERIOD_W = 22;
  localparam longint CMI_WAKE_FILTER_NS = 10000;
  localparam longint CMI_WAKE_MIN_CYC =
    (CMI_WAKE_FILTER_NS * CMI_CLK_HZ + 999_999_999) / 1_000_000_000;
  localparam int CMI_WAKE_W = 10;

  // Number of pin inputs passed through the synchroniser
  localparam int CMI_SYNC_W = 5;

  typedef enum logic [2:0] {
    CMI_ST_IDLE,
    CMI_ST_RX,
    CMI_ST_RX_ACK,
    CMI_ST_TX,
    CMI_ST_TX_ACK
  } cmi_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } cmi_bus_ev_s;

endpackage : cmi_pkg

// ---- src/cmi_sync3.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module cmi_sync3 import cmi_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [CMI_SYNC_W-1:0] async_in,
  output logic [CMI_SYNC_W-1:0] sync_out
);

  logic [CMI_SYNC_W-1:0] meta_ff;
  logic [CMI_SYNC_W-1:0] mid_ff;
  logic [CMI_SYNC_W-1:0] last_ff;
  logic [CMI_SYNC_W-1:0] out_ff;
  logic [CMI_SYNC_W-1:0] nxt_out;

  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < CMI_SYNC_W; i++) begin
      if (mid_ff[i] == last_ff[i]) begin
        nxt_out[i] = last_ff[i];
      end
    end
  end

  // Reset SCL and SDA to the idle level of an open-drain bus (high); the other three pins reset low
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 5'h03;
      mid_ff <= 5'h03;
      last_ff <= 5'h03;
      out_ff <= 5'h03;
    end else begin
      meta_ff <= async_in;
      mid_ff <= meta_ff;
      last_ff <= mid_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;

endmodule : cmi_sync3
`default_nettype wire

// ---- src/cmi_wake_filter.sv ----
// Qualifies the wake comparator: a level held above threshold long enough
`timescale 1ns/10ps
`default_nettype none
module cmi_wake_filter import cmi_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wake_above,
  output logic wake_detect
);

  logic [CMI_WAKE_W-1:0] cnt_ff;
  logic [CMI_WAKE_W-1:0] nxt_cnt;
  logic det_ff;
  logic nxt_det;

  // One pulse per qualified excursion; a glitch low restarts the count
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_det = 1'b0;
    if (!wake_above) begin
      nxt_cnt = '0;
    end else if (cnt_ff < CMI_WAKE_W'(CMI_WAKE_MIN_CYC)) begin
      nxt_cnt = cnt_ff + 10'h001;
    end else if (cnt_ff == CMI_WAKE_W'(CMI_WAKE_MIN_CYC)) begin
      nxt_cnt = cnt_ff + 10'h001;
      nxt_det = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      det_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      det_ff <= nxt_det;
    end
  end

  assign wake_detect = det_ff;

endmodule : cmi_wake_filter
`default_nettype wire

// ---- test/cmi_host_model.sv ----
// Host I2C master model with the pull-up of the shared SDA wire
`timescale 1ns/10ps
`default_nettype none
module cmi_host_model #(
  parameter int QTR_NS = 80
) (
  input wire logic slave_oe,
  output logic scl,
  output logic sda
);
  logic sda_low;

  // Wired-AND with pull-up, so a released line reads high
  assign sda = ~(sda_low | slave_oe);

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Phases stretched past the slave's pin latency of about five clocks
  task automatic put_bit(input logic b, output logic seen);
    sda_low = ~b;
    #(QTR_NS);
    scl = 1'b1;
    #(QTR_NS);
    seen = sda;
    #(QTR_NS);
    scl = 1'b0;
    #(QTR_NS);
  endtask : put_bit

  task automatic start_cond();
    sda_low = 1'b0;
    #(QTR_NS);
    scl = 1'b1;
    #(2*QTR_NS);
    sda_low = 1'b1;
    #(2*QTR_NS);
    scl = 1'b0;
    #(QTR_NS);
  endtask : start_cond

  task automatic stop_cond();
    sda_low = 1'b1;
    #(QTR_NS);
    scl = 1'b1;
    #(2*QTR_NS);
    sda_low = 1'b0;
    #(2*QTR_NS);
  endtask : stop_cond

  task automatic send_bits(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
  endtask : send_bits

  task automatic send_byte(input logic [7:0] d, output logic ack);
    send_bits(d);
    put_bit(1'b1, ack);
  endtask : send_byte

  // Last byte is left unacknowledged
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(last, s);
  endtask : recv_byte
endmodule : cmi_host_model
`default_nettype wire

// ---- test/tb_cell_monitor_i2c_slave_regs.sv ----
// Self-checking bench of the cell monitor I2C slave and its register bank
`timescale 1ns/10ps
`default_nettype none
module tb_cell_monitor_i2c_slave_regs import cmi_pkg::*;;
  localparam longint TS = 2000;
  localparam longint TL = 4000;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] dat;
    logic [7:0] rd;
  } cmi_row_s;
  logic clock, sys_rst, scl, sda, sda_oe, trim_long_timeout;
  logic wake_above_threshold, wake_below_release, bus_busy;
  logic sleep_request, external_wake_flag, monitor_enable;
  logic [2:0] cell_tap_select;
  logic [7:0] monitor_switch_sel, balance_switch_enables;
  logic [7:0] ctrl_m, bal_m, rd_v;
  logic ack;
  logic sda_drv;
  int cnt;
  int bad_count = 0;
  int n_tests = 0;
  logic [6:0] bad_addr [2] = '{7'h5d, 7'h1c};
  cmi_row_s rows [16] = '{24'h015555, 24'h002020, 24'h002121, 24'h002222, 24'h002323,
    24'h002424, 24'h002525, 24'h002626, 24'h002727, 24'h001a1a, 24'h003f3f, 24'h01aaaa,
    24'h008080, 24'h010f0f, 24'h000000, 24'h057700};

  cmi_i2c_slave_regs #(
    .BUS_TIMEOUT_PERIOD_SHORT_CYC(TS),
    .BUS_TIMEOUT_PERIOD_LONG_CYC(TL)
  ) DUT (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_drv),
    .sda_oe(sda_oe),
    .trim_long_timeout(trim_long_timeout),
    .wake_above_threshold(wake_above_threshold),
    .wake_below_release(wake_below_release),
    .bus_busy(bus_busy),
    .sleep_request(sleep_request),
    .external_wake_flag(external_wake_flag),
    .monitor_enable(monitor_enable),
    .cell_tap_select(cell_tap_select),
    .monitor_switch_sel(monitor_switch_sel),
    .balance_switch_enables(balance_switch_enables)
  );

  cmi_host_model host (
    .slave_oe(sda_oe),
    .scl(scl),
    .sda(sda)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic chk_outs();
    chk("sleep", ctrl_m[7], sleep_request);
    chk("mon_en", ctrl_m[5], monitor_enable);
    chk("tap", ctrl_m[2:0], cell_tap_select);
    chk("tap_sw", ctrl_m[5] ? 8'h01 << ctrl_m[2:0] : 8'h00, monitor_switch_sel);
    chk("bal", bal_m, balance_switch_enables);
  endtask : chk_outs

  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    host.start_cond();
    host.send_byte({CMI_SLAVE_ADDR, 1'b0}, ack);
    chk("addr_ack", 0, ack);
    host.send_byte(p, ack);
    chk("ptr_ack", 0, ack);
    host.send_byte(d, ack);
    chk("data_ack", 0, ack);
    host.stop_cond();
    if (p == CMI_CTRL_OFS) begin
      if (d[7] && !ctrl_m[7]) bal_m = 8'h00;
      ctrl_m = d;
    end else if (p == CMI_BAL_OFS) begin
      bal_m = d;
    end
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
    host.start_cond();
    host.send_byte({CMI_SLAVE_ADDR, 1'b0}, ack);
    host.send_byte(p, ack);
    host.start_cond();
    chk("busy_sr", 1, bus_busy);
    host.send_byte({CMI_SLAVE_ADDR, 1'b1}, ack);
    chk("rd_ack", 0, ack);
    host.recv_byte(1'b1, d);
    host.stop_cond();
    cyc(2);
    chk("busy_p", 0, bus_busy);
  endtask : rd_reg

  task automatic do_reset();
    sys_rst = 1'b1;
    cyc(10);
    sys_rst = 1'b0;
    cyc(4);
    ctrl_m = CMI_CTRL_RST;
    bal_m = CMI_BAL_RST;
    chk_outs();
    chk("busy_rst", 0, bus_busy);
    chk("oe_rst", 0, sda_oe);
    chk("sda_out", 0, sda_drv);
  endtask : do_reset

  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    sys_rst = 1'b1;
    trim_long_timeout = 1'b0;
    wake_above_threshold = 1'b0;
    wake_below_release = 1'b0;
    cyc(1);
    do_reset();
    foreach (rows[i]) begin
      wr_reg(rows[i].ptr, rows[i].dat);
      rd_reg(rows[i].ptr, rd_v);
      chk("rd", rows[i].rd, rd_v);
      chk_outs();
    end
    // Foreign addresses must leave the balance byte alone
    foreach (bad_addr[i]) begin
      host.start_cond();
      host.send_byte({bad_addr[i], 1'b0}, ack);
      chk("nack", 1, ack);
      host.send_byte(CMI_BAL_OFS, ack);
      host.send_byte(8'hff, ack);
      host.stop_cond();
      chk_outs();
    end
    wr_reg(CMI_CTRL_OFS, 8'h80);
    wake_above_threshold = 1'b1;
    cyc(400);
    wake_above_threshold = 1'b0;
    cyc(20);
    chk("wake_short", 0, external_wake_flag);
    wake_above_threshold = 1'b1;
    cnt = 0;
    while (external_wake_flag !== 1'b1 && cnt < 700) begin
      @(posedge clock);
      cnt++;
    end
    #1;
    chk("wake_time", 1, cnt >= 500 && cnt <= 515);
    chk("wake_slp", 0, sleep_request);
    wake_above_threshold = 1'b0;
    wake_below_release = 1'b1;
    cnt = 0;
    while (external_wake_flag !== 1'b0 && cnt < 20) begin
      @(posedge clock);
      cnt++;
    end
    #1;
    chk("wake_clr", 1, cnt <= 6);
    wake_below_release = 1'b0;
    wr_reg(CMI_CTRL_OFS, 8'h40);
    chk("host_flag", 1, external_wake_flag);
    wr_reg(CMI_CTRL_OFS, 8'h80);
    chk("slp_ignored", 0, sleep_request);
    wr_reg(CMI_CTRL_OFS, 8'h00);
    wr_reg(CMI_CTRL_OFS, 8'h80);
    chk("slp_ok", 1, sleep_request);
    wr_reg(CMI_BAL_OFS, 8'h3c);
    // Acked read byte makes the slave repeat the same register
    host.start_cond();
    host.send_byte({CMI_SLAVE_ADDR, 1'b1}, ack);
    chk("burst_ack", 0, ack);
    host.recv_byte(1'b0, rd_v);
    chk("burst0", 8'h3c, rd_v);
    host.recv_byte(1'b1, rd_v);
    chk("burst1", 8'h3c, rd_v);
    host.stop_cond();
    // Stall with the slave holding its address acknowledge
    for (int t = 0; t < 2; t++) begin
      trim_long_timeout = t[0];
      host.start_cond();
      host.send_bits({CMI_SLAVE_ADDR, 1'b0});
      cyc(8);
      chk("oe_ack", 1, sda_oe);
      cnt = 0;
      while (bus_busy === 1'b1 && cnt < 5000) begin
        @(posedge clock);
        cnt++;
      end
      #1;
      chk("bus_timeout_period", 1, cnt >= (t ? TL : TS) - 20 && cnt <= (t ? TL : TS) + 8);
      chk("bus_timeout_period_oe", 0, sda_oe);
      chk("bus_timeout_period_reg", 8'h3c, balance_switch_enables);
      host.stop_cond();
    end
    do_reset();
    rd_reg(CMI_BAL_OFS, rd_v);
    chk("rst_bal", CMI_BAL_RST, rd_v);
    print_verdict();
  end
endmodule : tb_cell_monitor_i2c_slave_regs
`default_nettype wire
